// ===== src/adm_pkg.sv
// constants, types and helpers for the analog difference and window monitor
// assumes one 20 mhz clock and an axi4-lite register port
package adm_pkg;
  // generic word carried through all scaling arithmetic
  typedef logic signed [31:0] adm_word_type;
  // bus geometry and answers
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] ADDR_GAIN = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_ON_THR = 8'h08;
  localparam logic [7:0] ADDR_OFF_THR = 8'h0c;
  localparam logic [7:0] ADDR_UPPER = 8'h10;
  localparam logic [7:0] ADDR_LOWER = 8'h14;
  localparam logic [7:0] ADDR_SRC = 8'h18;
  localparam logic [7:0] ADDR_CONFIG = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_DIFF = 8'h24;
  localparam logic [7:0] ADDR_REF = 8'h28;
  // value ranges: gain in hundredths
  localparam adm_word_type GAIN_MAX = 32'sh0000_03e8;   // 10.00
  localparam adm_word_type OFFSET_MAX = 32'sh0000_2710; // 10000
  localparam adm_word_type THR_MAX = 32'sh0000_4e20;    // 20000
  localparam adm_word_type MARGIN_MAX = 32'sh0000_4e20; // 20000
  localparam adm_word_type MARGIN_MIN = 32'sh0000_0000;
  localparam logic [10:0] RAW_MAX = 11'h3e8;            // 1000
  localparam adm_word_type GAIN_SCALE = 32'sh0000_0064; // 100
  // parameter sources: four fields of four bits in the source register
  localparam int NUM_SRC = 4;
  localparam int NUM_BLOCKS = 8;
  localparam int NUM_SCALED = 3;
  localparam int SRC_FIELD_W = 4;
  localparam int SRC_USE_BIT = 3;
  localparam int SRC_ON = 0;
  localparam int SRC_OFF = 1;
  localparam int SRC_UPPER = 2;
  localparam int SRC_LOWER = 3;
  // scaled channel order
  localparam int CH_X = 0;
  localparam int CH_Y = 1;
  localparam int CH_MON = 2;
  // config and status fields
  localparam int CFG_DEC_LSB = 0;
  localparam int CFG_DEC_MSB = 1;
  localparam int CFG_RETAIN_BIT = 2;
  localparam int STAT_CMP_BIT = 0;
  localparam int STAT_MON_BIT = 1;
  localparam int STAT_ARMED_BIT = 2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // saturate a signed value into [lo, hi]
  function automatic adm_word_type adm_clamp(input adm_word_type v,
                                             input adm_word_type lo,
                                             input adm_word_type hi);
    adm_word_type r;
    r = v;
    if (v < lo) r = lo;
    if (v > hi) r = hi;
    return r;
  endfunction

  // merge written byte lanes into an old word
  function automatic logic [31:0] adm_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return r;
  endfunction
endpackage

// ===== src/adm_scale_if.sv
// shared gain and offset carried from the register file to the scalers
// assumes both ends sit on the same clock
interface adm_scale_if;
  logic signed [31:0] gain;
  logic signed [31:0] offset;
  modport cfg_side (output gain, output offset);
  modport use_side (input gain, input offset);
endinterface

// ===== src/adm_scaler.sv
// one operand scaler: actual = raw * gain / 100 + offset, registered
// assumes raw comes from logic on the same clock
module adm_scaler
  import adm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // scaling parameters
  adm_scale_if.use_side cfg,
  // operand in and actual value out
  input wire logic [10:0] raw,
  output adm_word_type actual
);
  adm_word_type raw_word;

  // operand clipped to the channel range
  assign raw_word = (raw > RAW_MAX) ? adm_word_type'({21'h0, RAW_MAX})
                                    : adm_word_type'({21'h0, raw});

  // gain then offset, same for every operand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      actual <= '0;
    end else begin
      actual <= (raw_word * cfg.gain) / GAIN_SCALE + cfg.offset;
    end
  end

  property p_scale;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> actual == ($past(raw_word) * $past(cfg.gain)) / GAIN_SCALE
                         + $past(cfg.offset);
  endproperty
  a_scale: assert property (p_scale) else $error("scaled value wrong");
endmodule // adm_scaler

// ===== src/adm_param_src.sv
// picks a threshold or margin from a constant or another block's value
// assumes block values are already registered by their owners
module adm_param_src
  import adm_pkg::*;
(
  // selection
  input wire logic [SRC_FIELD_W-1:0] sel,
  input wire adm_word_type const_value,
  // live values of other blocks
  input wire logic [NUM_BLOCKS-1:0][31:0] block_values,
  // chosen value
  output adm_word_type value
);
  // block number in the low bits, use flag on top
  assign value = sel[SRC_USE_BIT]
                 ? adm_word_type'(block_values[sel[SRC_USE_BIT-1:0]])
                 : const_value;
endmodule // adm_param_src

// ===== src/adm_top.sv
// analog difference comparator and window monitor with axi4-lite registers
// assumes operands, enable and block values come from same-clock logic
module adm_top
  import adm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog operands
  input wire logic [10:0] first_analog_input,
  input wire logic [10:0] second_analog_input,
  input wire logic [10:0] monitored_input,
  input wire logic monitor_enable,
  input wire logic [NUM_BLOCKS-1:0][31:0] block_values,
  // nonvolatile store
  input wire logic nv_restore,
  input wire adm_word_type nv_ref_in,
  input wire logic nv_state_in,
  output logic nv_write,
  output adm_word_type nv_ref,
  output logic nv_state,
  // results
  output logic cmp_out,
  output logic mon_out
);
  adm_word_type gain_reg, offset_reg, on_reg, off_reg;
  adm_word_type upper_reg, lower_reg;
  logic [15:0] src_reg;
  logic [CFG_RETAIN_BIT:0] config_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_got_reg, w_got_reg;
  logic wr_fire, wr_hit, rd_hit;
  logic [31:0] rd_word;
  adm_word_type scaled [NUM_SCALED];
  logic [10:0] raw_in [NUM_SCALED];
  adm_word_type par_const [NUM_SRC];
  adm_word_type par_value [NUM_SRC];
  adm_word_type diff_reg, ref_reg;
  logic en_d1_reg, en_d2_reg, armed_reg;
  logic capture, outside, mon_next;
  adm_word_type on_val, off_val;
  adm_word_type band_hi, band_lo;

  adm_scale_if scale_bus();

  // shared gain and offset to every scaler
  assign scale_bus.gain = gain_reg;
  assign scale_bus.offset = offset_reg;
  assign raw_in[CH_X] = first_analog_input;
  assign raw_in[CH_Y] = second_analog_input;
  assign raw_in[CH_MON] = monitored_input;

  // one scaler per operand
  for (genvar g = 0; g < NUM_SCALED; g++) begin : g_scale
    adm_scaler u_scale (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(scale_bus.use_side),
      .raw(raw_in[g]),
      .actual(scaled[g])
    );
  end

  // constant or block-sourced thresholds and margins
  assign par_const[SRC_ON] = on_reg;
  assign par_const[SRC_OFF] = off_reg;
  assign par_const[SRC_UPPER] = upper_reg;
  assign par_const[SRC_LOWER] = lower_reg;
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    adm_param_src u_src (
      .sel(src_reg[g*SRC_FIELD_W +: SRC_FIELD_W]),
      .const_value(par_const[g]),
      .block_values(block_values),
      .value(par_value[g])
    );
  end
  assign on_val = par_value[SRC_ON];
  assign off_val = par_value[SRC_OFF];

  // write decode
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_hit = (aw_addr_reg <= ADDR_CONFIG) && (aw_addr_reg[1:0] == 2'h0);

  // write address, data and response channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register file, gain, offset, thresholds and margins saturated to their ranges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_reg <= GAIN_SCALE;
      offset_reg <= '0;
      on_reg <= '0;
      off_reg <= '0;
      upper_reg <= '0;
      lower_reg <= '0;
      src_reg <= '0;
      config_reg <= '0;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        ADDR_GAIN: gain_reg <= adm_clamp(adm_merge(gain_reg, w_data_reg,
          w_strb_reg), -GAIN_MAX, GAIN_MAX);
        ADDR_OFFSET: offset_reg <= adm_clamp(adm_merge(offset_reg,
          w_data_reg, w_strb_reg), -OFFSET_MAX, OFFSET_MAX);
        ADDR_ON_THR: on_reg <= adm_clamp(adm_merge(on_reg, w_data_reg,
          w_strb_reg), -THR_MAX, THR_MAX);
        ADDR_OFF_THR: off_reg <= adm_clamp(adm_merge(off_reg, w_data_reg,
          w_strb_reg), -THR_MAX, THR_MAX);
        ADDR_UPPER: upper_reg <= adm_clamp(adm_merge(upper_reg, w_data_reg,
          w_strb_reg), MARGIN_MIN, MARGIN_MAX);
        ADDR_LOWER: lower_reg <= adm_clamp(adm_merge(lower_reg, w_data_reg,
          w_strb_reg), MARGIN_MIN, MARGIN_MAX);
        ADDR_SRC: src_reg <= 16'(adm_merge({16'h0, src_reg}, w_data_reg,
          w_strb_reg));
        ADDR_CONFIG: config_reg <= (CFG_RETAIN_BIT + 1)'(adm_merge(
          {29'h0, config_reg}, w_data_reg, w_strb_reg));
        default: ;
      endcase
    end
  end

  // read mux; decimal count is stored for display only
  always_comb begin
    rd_hit = 1'b1;
    rd_word = ZERO_WORD;
    unique case (s_axi_araddr)
      ADDR_GAIN: rd_word = gain_reg;
      ADDR_OFFSET: rd_word = offset_reg;
      ADDR_ON_THR: rd_word = on_reg;
      ADDR_OFF_THR: rd_word = off_reg;
      ADDR_UPPER: rd_word = upper_reg;
      ADDR_LOWER: rd_word = lower_reg;
      ADDR_SRC: rd_word = {16'h0, src_reg};
      ADDR_CONFIG: rd_word = {29'h0, config_reg};
      ADDR_STATUS: rd_word = {29'h0, armed_reg, mon_out, cmp_out};
      ADDR_DIFF: rd_word = diff_reg;
      ADDR_REF: rd_word = ref_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // read address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // difference of the two actual values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diff_reg <= '0;
    end else begin
      diff_reg <= scaled[CH_X] - scaled[CH_Y];
    end
  end

  // comparator: hysteresis or window by threshold order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_out <= 1'b0;
    end else if (on_val >= off_val) begin
      if (diff_reg > on_val) cmp_out <= 1'b1;
      else if (diff_reg <= off_val) cmp_out <= 1'b0;
    end else begin
      cmp_out <= (diff_reg >= on_val) && (diff_reg < off_val);
    end
  end

  // monitor band; enable delayed to line up with the scaled input
  assign capture = en_d1_reg && !en_d2_reg;
  assign band_hi = ref_reg + par_value[SRC_UPPER];
  assign band_lo = ref_reg - par_value[SRC_LOWER];
  assign outside = (scaled[CH_MON] > band_hi) || (scaled[CH_MON] < band_lo);
  assign mon_next = en_d1_reg && !capture && armed_reg && outside;

  // enable edge, reference capture and nonvolatile restore
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_d1_reg <= 1'b0;
      en_d2_reg <= 1'b0;
      ref_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      en_d1_reg <= monitor_enable;
      en_d2_reg <= en_d1_reg;
      if (capture) begin
        ref_reg <= scaled[CH_MON];
        armed_reg <= 1'b1;
      end else if (nv_restore && config_reg[CFG_RETAIN_BIT]) begin
        ref_reg <= nv_ref_in;
        armed_reg <= 1'b1;
      end
    end
  end

  // monitor output; cleared inside the band or with enable low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_out <= 1'b0;
    end else if (nv_restore && config_reg[CFG_RETAIN_BIT] && en_d1_reg) begin
      mon_out <= nv_state_in;
    end else begin
      mon_out <= mon_next;
    end
  end

  // store retained state when it changes, only while the retain bit of config is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_write <= 1'b0;
      nv_ref <= '0;
      nv_state <= 1'b0;
    end else begin
      nv_write <= config_reg[CFG_RETAIN_BIT]
                  && (capture || (mon_next != mon_out));
      nv_ref <= capture ? scaled[CH_MON] : ref_reg;
      nv_state <= mon_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_diff;
    1'b1 |=> diff_reg == $past(scaled[CH_X]) - $past(scaled[CH_Y]);
  endproperty
  a_diff: assert property (p_diff) else $error("difference wrong");

  property p_hyst_set;
    (on_val >= off_val) && (diff_reg > on_val) |=> cmp_out;
  endproperty
  a_hyst_set: assert property (p_hyst_set) else $error("no set");

  property p_hyst_clr;
    (on_val >= off_val) && (diff_reg <= off_val) |=> !cmp_out;
  endproperty
  a_hyst_clr: assert property (p_hyst_clr) else $error("no clear");

  property p_hyst_hold;
    (on_val >= off_val) && (diff_reg <= on_val) && (diff_reg > off_val)
      |=> $stable(cmp_out);
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("no hold");

  property p_window;
    (on_val < off_val) |=> cmp_out == $past((diff_reg >= on_val)
                                            && (diff_reg < off_val));
  endproperty
  a_window: assert property (p_window) else $error("window wrong");

  property p_capture;
    !monitor_enable ##1 monitor_enable |=> ##1
      ref_reg == $past(scaled[CH_MON]);
  endproperty
  a_capture: assert property (p_capture) else $error("no capture");

  property p_mon_set;
    en_d1_reg && armed_reg && !capture && outside
      && !(nv_restore && config_reg[CFG_RETAIN_BIT]) |=> mon_out;
  endproperty
  a_mon_set: assert property (p_mon_set) else $error("mon not set");

  property p_mon_off;
    !monitor_enable |=> ##1 !mon_out;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("mon not off");

  property p_ranges;
    (gain_reg <= GAIN_MAX) && (gain_reg >= -GAIN_MAX)
      && (upper_reg >= MARGIN_MIN) && (lower_reg <= MARGIN_MAX);
  endproperty
  a_ranges: assert property (p_ranges) else $error("range broken");

  c_cmp_rise: cover property (!cmp_out ##1 cmp_out);
  c_mon_rise: cover property (!mon_out ##1 mon_out);
  c_capture: cover property (capture);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // adm_top

// ===== dv/adm_src_model.sv
// model of the analog channels and of other blocks feeding the monitor
// assumes bench commands on the same clock; outputs change after each edge
module adm_src_model
  import adm_pkg::*;
(
  // clock
  input wire logic aclk,
  // commanded values
  input wire logic [10:0] x_cmd,
  input wire logic [10:0] y_cmd,
  input wire logic [10:0] m_cmd,
  input wire logic en_cmd,
  input wire adm_word_type blk_cmd,
  // channel and block outputs
  output logic [10:0] first_analog_input,
  output logic [10:0] second_analog_input,
  output logic [10:0] monitored_input,
  output logic monitor_enable,
  output logic [NUM_BLOCKS-1:0][31:0] block_values
);
  timeunit 1ns;
  timeprecision 1ns;

  // a channel never reports beyond its full range
  function automatic logic [10:0] clip(input logic [10:0] v);
    return (v > RAW_MAX) ? RAW_MAX : v;
  endfunction

  // channels and block values refreshed after each edge
  always @(posedge aclk) begin
    first_analog_input <= clip(x_cmd);
    second_analog_input <= clip(y_cmd);
    monitored_input <= clip(m_cmd);
    monitor_enable <= en_cmd;
    // block 5 is commanded, the others carry filler values
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      block_values[i] <= (i == 5) ? blk_cmd : 32'(i * 7 + 3);
    end
  end
endmodule // adm_src_model

// ===== dv/testbench.sv
// self-checking bench for adm_top: registers over axi4-lite, analog model
// assumes the analog model adds one cycle ahead of the design pipeline
module testbench
  import adm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // bus, model command and design result signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] x = 11'h0, y = 11'h0, m = 11'h0, fa, sa, mi;
  logic en = 1'b0, nv_restore = 1'b0, nv_state_in = 1'b0;
  adm_word_type blk = 32'h0, nv_ref_in = 32'h0, nv_ref;
  logic me, nv_write, nv_state, cmp_out, mon_out;
  logic [NUM_BLOCKS-1:0][31:0] bv;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int failures = 0, samples_checked = 0, nvw = 0, g, o, xv, yv;
  // clamp, hysteresis, window and monitor tables
  logic [7:0] ca[7] = '{ADDR_GAIN, ADDR_GAIN, ADDR_OFFSET, ADDR_ON_THR,
    ADDR_OFF_THR, ADDR_UPPER, ADDR_LOWER};
  logic [31:0] cw[7] = '{32'h7d0, 32'hffffec78, 32'h4e20, 32'h7530,
    32'hffff8ad0, 32'hfffffffb, 32'h61a8};
  logic [31:0] ce[7] = '{32'h3e8, 32'hfffffc18, 32'h2710, 32'h4e20,
    32'hffffb1e0, 32'h0, 32'h4e20};
  logic [10:0] hx[7] = '{11'h0, 11'h191, 11'h190, 11'hc9, 11'hc8, 11'h190,
    11'h191};
  logic [10:0] wx[5] = '{11'h63, 11'h64, 11'h12b, 11'h12c, 11'hc8};
  logic [10:0] mx[6] = '{11'h136, 11'h146, 11'h145, 11'h11c, 11'h11d,
    11'hc8};
  logic [6:0] he = 7'h4e;
  logic [4:0] we = 5'h16;
  logic [5:0] mex = 6'h2a;

  // 20 mhz clock
  always #25 aclk = ~aclk;

  adm_src_model adm_src_model_i (.aclk(aclk), .x_cmd(x), .y_cmd(y),
    .m_cmd(m), .en_cmd(en), .blk_cmd(blk), .first_analog_input(fa),
    .second_analog_input(sa), .monitored_input(mi), .monitor_enable(me),
    .block_values(bv));

  adm_top adm_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .first_analog_input(fa),
    .second_analog_input(sa), .monitored_input(mi), .monitor_enable(me),
    .block_values(bv), .nv_restore(nv_restore), .nv_ref_in(nv_ref_in),
    .nv_state_in(nv_state_in), .nv_write(nv_write), .nv_ref(nv_ref),
    .nv_state(nv_state), .cmp_out(cmp_out), .mon_out(mon_out));

  // compare one value and count it
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a wait that ran out
  task automatic hang(input string what);
    failures++;
    $display("CHECK FAILED %s expected answer seen none", what);
    end_sim();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // axi4-lite write, expected response noted
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    bit ad, dd;
    ad = 0;
    dd = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !(ad && dd); n++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end
    if (!(ad && dd)) hang("write take");
    bready <= 1'b1;
    for (n = 0; n < 50 && !(bready && bvalid); n++) @(posedge aclk);
    if (n == 50) hang("write answer");
    bready <= 1'b0;
  endtask

  // axi4-lite read, expected word and response noted
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !(arvalid && arready); n++) @(posedge aclk);
    if (n == 50) hang("read take");
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (n = 0; n < 50 && !(rready && rvalid); n++) @(posedge aclk);
    if (n == 50) hang("read answer");
    rready <= 1'b0;
  endtask

  // bus answers taken against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready && bq.size() > 0)
      check("bresp", 32'(bresp), 32'(bq.pop_front()));
    if (rvalid && rready && rq.size() > 0) begin
      check("rdata", rdata, rq[0][31:0]);
      check("rresp", 32'(rresp), 32'(rq[0][33:32]));
      void'(rq.pop_front());
    end
    if (nv_write)
      nvw++;
  end

  // one comparator point, settled through the pipeline
  task automatic cmp_step(input logic [10:0] v, input logic e);
    x <= v;
    tick(6);
    check("cmp_out", 32'(cmp_out), 32'(e));
  endtask

  // one monitor point
  task automatic mon_step(input logic [10:0] v, input logic e);
    m <= v;
    tick(6);
    check("mon_out", 32'(mon_out), 32'(e));
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hcabe));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_GAIN, 32'h64, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(8'h2c, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h7, RESP_SLVERR);
    wstrb <= 4'h1;
    wr(ADDR_ON_THR, 32'h1234_5678, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_ON_THR, 32'h78, RESP_OKAY);
    $display("test reset and map done");
    for (int i = 0; i < 7; i++) begin
      wr(ca[i], cw[i], RESP_OKAY);
      rd(ca[i], ce[i], RESP_OKAY);
    end
    $display("test range clamp done");
    for (int i = 0; i < 8; i++) begin
      g = int'($urandom_range(2000)) - 1000;
      o = int'($urandom_range(20000)) - 10000;
      xv = int'($urandom_range(1000));
      yv = int'($urandom_range(1000));
      wr(ADDR_GAIN, 32'(g), RESP_OKAY);
      wr(ADDR_OFFSET, 32'(o), RESP_OKAY);
      x <= 11'(xv);
      y <= 11'(yv);
      tick(6);
      rd(ADDR_DIFF, 32'((xv * g / GAIN_SCALE + o) - (yv * g / GAIN_SCALE + o)),
        RESP_OKAY);
    end
    $display("test scaling done");
    wr(ADDR_GAIN, 32'h64, RESP_OKAY);
    wr(ADDR_OFFSET, 32'h0, RESP_OKAY);
    wr(ADDR_ON_THR, 32'h190, RESP_OKAY);
    wr(ADDR_OFF_THR, 32'hc8, RESP_OKAY);
    y <= 11'h0;
    for (int i = 0; i < 7; i++) cmp_step(hx[i], he[i]);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    $display("test hysteresis done");
    wr(ADDR_ON_THR, 32'h64, RESP_OKAY);
    wr(ADDR_OFF_THR, 32'h12c, RESP_OKAY);
    for (int d = 0; d < 4; d += 3) begin
      wr(ADDR_CONFIG, 32'(d), RESP_OKAY);
      rd(ADDR_CONFIG, 32'(d), RESP_OKAY);
      for (int i = 0; i < 5; i++) cmp_step(wx[i], we[i]);
    end
    $display("test window done");
    wr(ADDR_ON_THR, 32'h190, RESP_OKAY);
    wr(ADDR_OFF_THR, 32'hc8, RESP_OKAY);
    blk <= 32'hfa;
    wr(ADDR_SRC, 32'hd, RESP_OKAY);
    cmp_step(11'h0, 1'b0);
    cmp_step(11'hfb, 1'b1);
    cmp_step(11'hf0, 1'b1);
    cmp_step(11'hc8, 1'b0);
    wr(ADDR_SRC, 32'h0, RESP_OKAY);
    $display("test block source done");
    wr(ADDR_GAIN, 32'hc8, RESP_OKAY);
    wr(ADDR_OFFSET, 32'hffffff9c, RESP_OKAY);
    wr(ADDR_UPPER, 32'h32, RESP_OKAY);
    wr(ADDR_LOWER, 32'h1e, RESP_OKAY);
    m <= 11'h12c;
    tick(3);
    en <= 1'b1;
    tick(6);
    rd(ADDR_REF, 32'h1f4, RESP_OKAY);
    for (int i = 0; i < 6; i++) mon_step(mx[i], mex[i]);
    en <= 1'b0;
    tick(6);
    check("mon_out low", 32'(mon_out), 32'h0);
    rd(ADDR_REF, 32'h1f4, RESP_OKAY);
    check("nv_write count", 32'(nvw), 32'h0);
    $display("test monitor done");
    wr(ADDR_CONFIG, 32'h4, RESP_OKAY);
    m <= 11'h190;
    tick(3);
    en <= 1'b1;
    tick(6);
    check("nv_ref", nv_ref, 32'h2bc);
    check("nv_write seen", 32'(nvw > 0), 32'h1);
    m <= 11'h1f4;
    tick(6);
    check("nv_state", 32'(nv_state), 32'h1);
    en <= 1'b0;
    nv_ref_in <= 32'h309;
    nv_state_in <= 1'b1;
    tick(3);
    nv_restore <= 1'b1;
    tick(1);
    nv_restore <= 1'b0;
    tick(6);
    rd(ADDR_REF, 32'h309, RESP_OKAY);
    $display("test retention done");
    tick(4);
    end_sim();
  end
endmodule // testbench
